// ### core/adrd_params.svh
// timing and size constants for the serial converter readout
// assumes a 100 MHz ref_clk on both ends
`ifndef ADRD_PARAMS_SVH
`define ADRD_PARAMS_SVH
`define ADRD_CLK_NS 10
`define ADRD_BITS 12
`define ADRD_WORD 16
`define ADRD_NUM_SEL 2
`define ADRD_FIFO_DEPTH 8
`define ADRD_HALF_NS 500
`define ADRD_WAKE_NS 5000
`define ADRD_SELHI_NS 2000
`define ADRD_LAST_FALL 13
`define ADRD_FIRST_DATA_FALL 2
`endif

// ### core/adrd_pkg.sv
// types shared by both ends of the serial converter readout
// assumes adrd_params.svh is on the include path
`include "adrd_params.svh"
package adrd_pkg;
	typedef logic [`ADRD_BITS-1:0] adrd_code_t;
	typedef enum logic [1:0] {DEV_IDLE, DEV_SAMPLE, DEV_CONV, DEV_DONE} adrd_dev_state_t;
	typedef enum logic [2:0] {HOST_IDLE, HOST_WAKE, HOST_HI, HOST_LO} adrd_host_state_t;
endpackage

// ### core/adrd_link_if.sv
// three-wire link between host and converter
// the data line reads low when no converter drives it
`timescale 1ns/10ps
`include "adrd_params.svh"
interface adrd_link_if;
	logic sclk;
	logic [`ADRD_NUM_SEL-1:0] cs_n;
	logic dout;
	logic dout_oe;
	logic dout_line;
	assign dout_line = dout_oe ? dout : 1'b0;
	modport host (output sclk, output cs_n, input dout_line);
	modport device (input sclk, input cs_n, output dout, output dout_oe);
endinterface

// ### core/adrd_device.sv
// converter end: sampling, hold, 12 bit tests, result shifted msb first
// assumes sclk and chip select come from another domain
`timescale 1ns/10ps
`include "adrd_params.svh"
module adrd_device
	import adrd_pkg::*;
#(
	parameter int SEL_IDX = 0,
	parameter bit SHUTDOWN = 1'b0
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	adrd_link_if.device link,
	input wire adrd_code_t analog_code,
	output logic sampling,
	output logic cap_on_neg,
	output logic converting
);
	logic [1:0] sclk_sync_r;
	logic [1:0] cs_sync_r;
	logic sclk_prev_r;
	adrd_dev_state_t state_r, state_nxt;
	adrd_code_t held_r, held_nxt;
	logic [3:0] fall_r, fall_nxt;
	logic dout_r, dout_nxt, oe_r, oe_nxt;
	logic samp_r, samp_nxt, neg_r, neg_nxt, conv_r, conv_nxt;
	logic fall_ev, cs_low;

	assign cs_low = ~cs_sync_r[1];
	// edge detect looks at the second stage only
	assign fall_ev = sclk_prev_r & ~sclk_sync_r[1];

	always_comb begin
		state_nxt = state_r;
		held_nxt = held_r;
		fall_nxt = fall_r;
		dout_nxt = dout_r;
		oe_nxt = cs_low;
		samp_nxt = 1'b0;
		neg_nxt = neg_r;
		conv_nxt = 1'b0;
		case (state_r)
			DEV_IDLE: begin
				neg_nxt = 1'b0;
				dout_nxt = 1'b0;
				fall_nxt = 4'h0;
				samp_nxt = ~SHUTDOWN;
				if (cs_low) begin
					state_nxt = DEV_SAMPLE;
					samp_nxt = 1'b1;
				end
			end
			DEV_SAMPLE: begin
				samp_nxt = 1'b1;
				if (!cs_low) begin
					state_nxt = DEV_IDLE;
				end else if (fall_ev) begin
					// hold and start converting on the first falling edge
					held_nxt = analog_code;
					neg_nxt = 1'b1;
					samp_nxt = 1'b0;
					conv_nxt = 1'b1;
					fall_nxt = 4'h1;
					dout_nxt = 1'b0;
					state_nxt = DEV_CONV;
				end
			end
			DEV_CONV: begin
				conv_nxt = 1'b1;
				if (!cs_low) begin
					state_nxt = DEV_IDLE;
				end else if (fall_ev) begin
					// one bit test per clock, presented after the falling edge
					dout_nxt = held_r[`ADRD_BITS-1];
					held_nxt = {held_r[`ADRD_BITS-2:0], 1'b0};
					fall_nxt = 4'(fall_r + 4'h1);
					if (fall_r == 4'(`ADRD_LAST_FALL - 1)) begin
						state_nxt = DEV_DONE;
						conv_nxt = 1'b0;
					end
				end
			end
			DEV_DONE: begin
				// capacitor stays on the negative side until the cycle ends
				if (fall_ev) begin
					dout_nxt = 1'b0;
				end
				if (!cs_low) begin
					state_nxt = DEV_IDLE;
				end
			end
			default: state_nxt = DEV_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sclk_sync_r <= 2'h0;
			cs_sync_r <= 2'h3;
			sclk_prev_r <= 1'b0;
			state_r <= DEV_IDLE;
			held_r <= '0;
			fall_r <= 4'h0;
			dout_r <= 1'b0;
			oe_r <= 1'b0;
			samp_r <= 1'b0;
			neg_r <= 1'b0;
			conv_r <= 1'b0;
		end else begin
			sclk_sync_r <= {sclk_sync_r[0], link.sclk};
			cs_sync_r <= {cs_sync_r[0], link.cs_n[SEL_IDX]};
			sclk_prev_r <= sclk_sync_r[1];
			state_r <= state_nxt;
			held_r <= held_nxt;
			fall_r <= fall_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			samp_r <= samp_nxt;
			neg_r <= neg_nxt;
			conv_r <= conv_nxt;
		end
	end

	assign link.dout = dout_r;
	assign link.dout_oe = oe_r;
	assign sampling = samp_r;
	assign cap_on_neg = neg_r;
	assign converting = conv_r;
endmodule

// ### core/adrd_host.sv
// host end: drives select and clock on port lines, collects results into a fifo
// assumes the data line comes from another domain and is synchronised here
// Summary of operation
// - host drives select, clock; samples data line
// - bit appears after falling edge, captured before next rise
// - result collected msb first, eight then four
// - result stored left-justified across two bytes
// - shutdown part: wait wake setup before clock
// - only one select low; selected converter drives
// - capacitor switches to negative input once
// - normal part samples select-high plus half-clock range
// - shutdown part samples from select fall
// - first clock fall holds and starts conversion
// - conversion takes twelve clocks, one test each
// - sampling starts select rise, or fall if shutdown
`timescale 1ns/10ps
`include "adrd_params.svh"

module adrd_fifo #(
	parameter int WIDTH = `ADRD_WORD,
	parameter int DEPTH = `ADRD_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	logic [WIDTH-1:0] head_nxt;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_comb begin
		wr_nxt = push ? bump(wr_r) : wr_r;
		rd_nxt = pop ? bump(rd_r) : rd_r;
		// registered head keeps the result port on a flop; bypass when the slot is new
		head_nxt = (push && wr_r == rd_nxt) ? in_data : mem_r[rd_nxt];
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = (AW+1)'(cnt_r + 1'b1);
		end else if (pop && !push) begin
			cnt_nxt = (AW+1)'(cnt_r - 1'b1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			in_ready <= cnt_nxt != (AW+1)'(DEPTH);
			out_valid <= cnt_nxt != '0;
			out_data <= head_nxt;
		end
	end

	// storage has no reset; only written words are shown while out_valid is high
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

endmodule

module adrd_host
	import adrd_pkg::*;
#(
	parameter bit SHUTDOWN = 1'b0
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	adrd_link_if.host link,
	input wire logic start_req,
	input wire logic [$clog2(`ADRD_NUM_SEL)-1:0] start_sel,
	output logic busy,
	output logic res_valid,
	input wire logic res_ready,
	output logic [`ADRD_WORD-1:0] res_data
);
	// least times round up to whole cycles
	function automatic int ns_to_cyc(input int ns);
		ns_to_cyc = (ns + `ADRD_CLK_NS - 1) / `ADRD_CLK_NS;
	endfunction
	localparam logic [15:0] HALF_CYC = 16'(ns_to_cyc(`ADRD_HALF_NS));
	localparam logic [15:0] WAKE_CYC = 16'(ns_to_cyc(`ADRD_WAKE_NS));
	localparam logic [15:0] SELHI_CYC = 16'(ns_to_cyc(`ADRD_SELHI_NS));
	localparam logic [15:0] SETUP_CYC = SHUTDOWN ? WAKE_CYC : HALF_CYC;

	adrd_host_state_t state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [3:0] fall_r, fall_nxt;
	logic [`ADRD_NUM_SEL-1:0] cs_r, cs_nxt;
	logic sclk_r, sclk_nxt;
	adrd_code_t shift_r, shift_nxt;
	logic busy_r, busy_nxt;
	logic push_r, push_nxt;
	logic [`ADRD_WORD-1:0] word_r, word_nxt;
	logic [1:0] din_sync_r;
	logic fifo_ready;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = (cnt_r == 16'hFFFF) ? cnt_r : 16'(cnt_r + 16'h1);
		fall_nxt = fall_r;
		cs_nxt = cs_r;
		sclk_nxt = sclk_r;
		shift_nxt = shift_r;
		busy_nxt = busy_r;
		push_nxt = 1'b0;
		word_nxt = word_r;
		case (state_r)
			HOST_IDLE: begin
				cs_nxt = '1;
				sclk_nxt = 1'b0;
				busy_nxt = 1'b0;
				// a free fifo slot is claimed before a conversion starts
				if (start_req && fifo_ready && cnt_r >= SELHI_CYC - 16'h1) begin
					cs_nxt = ~(`ADRD_NUM_SEL'(1) << start_sel);
					busy_nxt = 1'b1;
					cnt_nxt = 16'h0;
					fall_nxt = 4'h0;
					state_nxt = HOST_WAKE;
				end
			end
			HOST_WAKE: begin
				if (cnt_r >= SETUP_CYC - 16'h1) begin
					sclk_nxt = 1'b1;
					cnt_nxt = 16'h0;
					state_nxt = HOST_HI;
				end
			end
			HOST_HI: begin
				if (cnt_r >= HALF_CYC - 16'h1) begin
					sclk_nxt = 1'b0;
					fall_nxt = 4'(fall_r + 4'h1);
					cnt_nxt = 16'h0;
					state_nxt = HOST_LO;
				end
			end
			HOST_LO: begin
				// capture late in the low half, before the next rise
				if (cnt_r >= HALF_CYC - 16'h1) begin
					cnt_nxt = 16'h0;
					if (fall_r >= 4'(`ADRD_FIRST_DATA_FALL)) begin
						shift_nxt = {shift_r[`ADRD_BITS-2:0], din_sync_r[1]};
					end
					if (fall_r == 4'(`ADRD_LAST_FALL)) begin
						cs_nxt = '1;
						word_nxt = {shift_r[`ADRD_BITS-2:0], din_sync_r[1], 4'h0};
						push_nxt = 1'b1;
						state_nxt = HOST_IDLE;
					end else begin
						sclk_nxt = 1'b1;
						state_nxt = HOST_HI;
					end
				end
			end
			default: state_nxt = HOST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_r <= HOST_IDLE;
			cnt_r <= 16'h0;
			fall_r <= 4'h0;
			cs_r <= '1;
			sclk_r <= 1'b0;
			shift_r <= '0;
			busy_r <= 1'b0;
			push_r <= 1'b0;
			word_r <= '0;
			din_sync_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			fall_r <= fall_nxt;
			cs_r <= cs_nxt;
			sclk_r <= sclk_nxt;
			shift_r <= shift_nxt;
			busy_r <= busy_nxt;
			push_r <= push_nxt;
			word_r <= word_nxt;
			din_sync_r <= {din_sync_r[0], link.dout_line};
		end
	end

	adrd_fifo #(.WIDTH(`ADRD_WORD), .DEPTH(`ADRD_FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_valid(push_r),
		.in_ready(fifo_ready),
		.in_data(word_r),
		.out_valid(res_valid),
		.out_ready(res_ready),
		.out_data(res_data)
	);

	assign link.sclk = sclk_r;
	assign link.cs_n = cs_r;
	assign busy = busy_r;
endmodule

// ### test/adrd_link_monitor.sv
// checker on the host-converter link signals
// assumes the only converter sits on select 0
`timescale 1ns/10ps
`include "adrd_params.svh"
module adrd_link_monitor #(
	parameter int SETUP = 50,
	parameter int HALF = 50
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic [`ADRD_NUM_SEL-1:0] cs_n,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic dout_line
);
	logic idle;
	logic [11:0] lo_r, lo_nxt;
	logic [7:0] hi_r, hi_nxt;
	logic [3:0] fall_r, fall_nxt;
	assign idle = &cs_n;
	// saturating, so a long stall cannot wrap past the setup test
	always_comb begin
		lo_nxt = idle ? 12'h000 : lo_r + {11'h000, lo_r != 12'hFFF};
		hi_nxt = sclk ? hi_r + 8'h01 : 8'h00;
		fall_nxt = idle ? 4'h0 : fall_r + {3'h0, hi_r != 8'h00 && !sclk};
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			lo_r <= 12'h000;
			hi_r <= 8'h00;
			fall_r <= 4'h0;
		end else begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
			fall_r <= fall_nxt;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	sequence quiet;
		idle [*6];
	endsequence
	sequence frame_end;
		$rose(idle);
	endsequence
	one_select_a: assert property ($countones(~cs_n) <= 1)
		else $error("more than one select low");
	idle_clock_a: assert property (idle |-> !sclk)
		else $error("clock runs while deselected");
	sample_setup_a: assert property ($rose(sclk) |-> lo_r >= SETUP)
		else $error("clock rose before setup elapsed");
	half_period_a: assert property ($fell(sclk) |-> hi_r == HALF)
		else $error("clock high phase wrong length");
	bit_count_a: assert property (frame_end |-> fall_r == 4'hD)
		else $error("frame did not hold thirteen falls");
	bit_stable_a: assert property (sclk |-> $stable(dout_line))
		else $error("data moved while clock high");
	data_hold_a: assert property (sclk && dout_oe |-> $stable(dout))
		else $error("driven data moved while clock high");
	null_bit_a: assert property (fall_r == 4'h1 && sclk |-> !dout_line)
		else $error("null bit not low");
	oe_release_a: assert property (quiet |-> !dout_oe)
		else $error("converter drives while deselected");
	oe_select_a: assert property ($rose(dout_oe) |-> !cs_n[0])
		else $error("converter drove without its select");
endmodule

// ### test/testbench.sv
// bench: host and one converter on the link, results checked in order
// assumes the converter sits on select 0, select 1 is left empty
`timescale 1ns/10ps
`include "adrd_params.svh"
module testbench;
	import adrd_pkg::*;
	logic ref_clk = 0, reset_n = 0, start_req = 0, start_sel = 0, res_ready = 0, rmode = 0;
	adrd_code_t code = '0;
	logic busy, res_valid, sampling, cap_on_neg, converting, busy_d, cap_d;
	logic [15:0] res_data;
	logic [15:0] exp_q[$];
	int n_errors = 0, comparisons = 0, conv_n = 0, cap_n = 0;
	logic start_sd = 0, busy_sd, res_valid_sd, samp_sd, neg_sd, conv_sd, busy_sd_d;
	logic [15:0] res_data_sd;
	logic [15:0] exp_sd_q[$];
	int samp_n = 0;
	localparam int SD_SAMP = (`ADRD_WAKE_NS + `ADRD_HALF_NS) / `ADRD_CLK_NS;
	adrd_link_if link();
	adrd_link_if link_sd();
	adrd_host i_adrd_host (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.host),
		.start_req(start_req), .start_sel(start_sel), .busy(busy),
		.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
	adrd_device #(.SEL_IDX(0)) i_adrd_device (.ref_clk(ref_clk), .reset_n(reset_n),
		.link(link.device), .analog_code(code), .sampling(sampling),
		.cap_on_neg(cap_on_neg), .converting(converting));
	// second pair runs the power-shutdown variant on its own link
	adrd_host #(.SHUTDOWN(1'b1)) i_adrd_host_sd (.ref_clk(ref_clk), .reset_n(reset_n),
		.link(link_sd.host), .start_req(start_sd), .start_sel(1'b0), .busy(busy_sd),
		.res_valid(res_valid_sd), .res_ready(res_ready), .res_data(res_data_sd));
	adrd_device #(.SEL_IDX(0), .SHUTDOWN(1'b1)) i_adrd_device_sd (.ref_clk(ref_clk),
		.reset_n(reset_n), .link(link_sd.device), .analog_code(code), .sampling(samp_sd),
		.cap_on_neg(neg_sd), .converting(conv_sd));
	adrd_link_monitor #(.SETUP(50), .HALF(50)) i_adrd_link_monitor (.ref_clk(ref_clk),
		.reset_n(reset_n), .sclk(link.sclk), .cs_n(link.cs_n), .dout(link.dout),
		.dout_oe(link.dout_oe), .dout_line(link.dout_line));
	always #5 ref_clk = ~ref_clk;
	// random back-pressure so the fifo sees stalls mid-stream
	always @(posedge ref_clk) #1 res_ready = rmode & 1'($urandom);
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// take=0 expects the request to be refused
	task automatic convert(logic sel, adrd_code_t c, logic take);
		int i;
		@(posedge ref_clk) #1;
		start_sel = sel;
		code = c;
		start_req = 1;
		for (i = 0; i < 400 && busy !== 1'b1; i++) @(posedge ref_clk) #1;
		start_req = 0;
		check("busy", {15'h0, take}, {15'h0, busy});
		if (take) begin
			exp_q.push_back(sel ? 16'h0000 : {c, 4'h0});
			for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk) #1;
			check("busy done", 16'h0, {15'h0, busy});
		end
	endtask
	task automatic convert_sd(adrd_code_t c);
		int i;
		@(posedge ref_clk) #1;
		code = c;
		start_sd = 1;
		for (i = 0; i < 400 && busy_sd !== 1'b1; i++) @(posedge ref_clk) #1;
		start_sd = 0;
		check("busy shutdown", 16'h1, {15'h0, busy_sd});
		exp_sd_q.push_back({c, 4'h0});
		for (i = 0; i < 2500 && busy_sd !== 1'b0; i++) @(posedge ref_clk) #1;
		check("busy shutdown done", 16'h0, {15'h0, busy_sd});
	endtask
	task automatic drain;
		int i;
		for (i = 0; i < 500 && exp_q.size() + exp_sd_q.size() > 0; i++) @(posedge ref_clk);
		check("left over", 16'h0, 16'(exp_q.size() + exp_sd_q.size()));
	endtask
	always @(posedge ref_clk) begin
		if (res_valid === 1'b1 && res_ready === 1'b1) begin
			if (exp_q.size() == 0) check("extra result", 16'h0, 16'h1);
			else check("res_data", exp_q.pop_front(), res_data);
		end
		if (res_valid_sd === 1'b1 && res_ready === 1'b1) begin
			if (exp_sd_q.size() == 0) check("extra shutdown result", 16'h0, 16'h1);
			else check("res_data_sd", exp_sd_q.pop_front(), res_data_sd);
		end
		// shutdown window runs from select fall to first clock fall
		if (samp_sd === 1'b1) samp_n++;
		if (busy_sd === 1'b1 && busy_sd_d === 1'b0) samp_n = 0;
		if (busy_sd === 1'b0 && busy_sd_d === 1'b1) begin
			check("shutdown sample", 16'(SD_SAMP), 16'(samp_n));
		end
		busy_sd_d = busy_sd;
		if (converting === 1'b1) conv_n++;
		if (cap_on_neg === 1'b1 && cap_d === 1'b0) cap_n++;
		if (converting === 1'b1) check("sampling held", 16'h0, {15'h0, sampling});
		if (busy === 1'b1 && busy_d === 1'b0) begin
			check("sampling idle", 16'h1, {15'h0, sampling});
			conv_n = 0;
			cap_n = 0;
		end
		if (busy === 1'b0 && busy_d === 1'b1) begin
			check("conv cycles", start_sel ? 16'h0 : 16'h04B0, 16'(conv_n));
			check("cap switches", {15'h0, !start_sel}, 16'(cap_n));
		end
		busy_d = busy;
		cap_d = cap_on_neg;
	end
	initial begin
		#600000;
		n_errors++;
		$display("watchdog expired");
		results();
	end
	initial begin
		int k;
		void'($urandom(32'h8C0F1EB7));
		repeat (12) @(posedge ref_clk);
		#1 reset_n = 1;
		rmode = 1;
		convert(0, 12'h000, 1);
		convert(0, 12'hFFF, 1);
		for (k = 0; k < 3; k++) convert(0, adrd_code_t'($urandom), 1);
		drain();
		$display("test stream done");
		convert(1, 12'hA5A, 1);
		drain();
		$display("test empty select done");
		rmode = 0;
		for (k = 0; k < 8; k++) convert(0, adrd_code_t'($urandom), 1);
		convert(0, 12'h123, 0);
		check("res_valid full", 16'h1, {15'h0, res_valid});
		rmode = 1;
		drain();
		$display("test fifo full done");
		convert_sd(12'h5A3);
		convert_sd(adrd_code_t'($urandom));
		drain();
		$display("test shutdown done");
		results();
	end
endmodule
